// *** design/spg_port.sv ***
// Purpose: shared-pin general-purpose digital port with register access
// Assumes: single core_clk domain; pads resolved outside from out/oe
// Notes: PINS=4 or 8; bits at and above PINS read as zero
`timescale 1ns/100ps
// Contract
// R1: each pin has a direction bit, 0 output and 1 input, all reset to 0.
// R2: the eight-pin variant has a byte of direction bits, bit n for pin n.
// R3: pin 0 shares the positive reference terminal, pin 1 the negative, pins 2-7 analog inputs.
// R4: an output pin reads back its stored bit and is driven to that level.
// R5: a write to an input pin's data bit updates only the stored value.
// R6: data bit 0 means low, 1 means high, and all data bits reset to 0.
// R7: the pin data register sits at offset 0x0e and resets to 0x00.
// R8: a pin acts as a port pin only while its enable bit at offset 0x0c is one; here reads at 0x0e ignore that bit.
// R9: an input pin reads its synchronised level; unused upper bits read zero.
module spg_port
  import spg_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire spg_req_type bus_req,
  output logic [SPG_DATA_W-1:0] rdata,
  input wire logic [SPG_PIN_MAX-1:0] pad_in,
  output spg_pad_type pad_drv,
  output logic [SPG_PIN_MAX-1:0] port_claim
);
  logic [SPG_PIN_MAX-1:0] enable_r;
  logic [SPG_PIN_MAX-1:0] direction_r;
  logic [SPG_PIN_MAX-1:0] level_r;
  logic [SPG_PIN_MAX-1:0] pad_sync;
  logic [SPG_PIN_MAX-1:0] impl_mask;
  logic [SPG_PIN_MAX-1:0] level_view;
  logic [SPG_DATA_W-1:0] rdata_nxt;

  // mask of implemented pins, so the four-pin variant hides its top half
  genvar gi;
  generate
    for (gi = 0; gi < SPG_PIN_MAX; gi++) begin : g_pin
      assign impl_mask[gi] = (gi < PINS);
      // inputs show the synchronised pad, outputs the stored bit
      assign level_view[gi] = (direction_r[gi] == SPG_DIR_INPUT) ?
                              pad_sync[gi] : level_r[gi]; // R4 R9
    end
  endgenerate

  spg_sync #(
    .WIDTH(SPG_PIN_MAX)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in(pad_in),
    .sync_out(pad_sync)
  );

  logic wr_hit;
  assign wr_hit = clk_en && bus_req.wr;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enable_r <= SPG_RST_ENABLE; // R8
    end else if (wr_hit && bus_req.addr == SPG_OFF_ENABLE) begin
      enable_r <= bus_req.wdata & impl_mask; // R8
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      direction_r <= SPG_RST_DIRECTION; // R1
    end else if (wr_hit && bus_req.addr == SPG_OFF_DIRECTION) begin
      direction_r <= bus_req.wdata & impl_mask; // R1 R2
    end
  end

  // stored value updates whatever the direction; only output pins drive it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level_r <= SPG_RST_LEVEL; // R6 R7
    end else if (wr_hit && bus_req.addr == SPG_OFF_LEVEL) begin
      level_r <= bus_req.wdata & impl_mask; // R5 R7
    end
  end

  always_comb begin
    rdata_nxt = '0;
    case (bus_req.addr)
      SPG_OFF_ENABLE: rdata_nxt = enable_r;
      SPG_OFF_DIRECTION: rdata_nxt = direction_r;
      SPG_OFF_LEVEL: rdata_nxt = level_view & impl_mask; // R9
      default: rdata_nxt = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (clk_en) begin
      rdata <= bus_req.rd ? rdata_nxt : '0;
    end
  end

  // pad drive registered so outputs come from flops; one cycle after change
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pad_drv <= '0;
      port_claim <= '0;
    end else if (clk_en) begin
      // terminal order: pin0 refp, pin1 refn, pin n analog input n
      port_claim <= enable_r & impl_mask; // R3 R8
      pad_drv.oe <= enable_r & ~direction_r & impl_mask; // R1 R4 R8
      pad_drv.out <= level_r & enable_r & ~direction_r & impl_mask; // R4 R6
    end
  end
endmodule

// *** shared/spg_pkg.sv ***
// Purpose: constants and carriers for the shared-pin port
// Assumes: byte-wide registers on a plain strobe port
// Notes: offsets are byte register offsets of the device map
package spg_pkg;
  localparam int SPG_ADDR_W = 8;
  localparam int SPG_DATA_W = 8;
  localparam logic [7:0] SPG_OFF_ENABLE = 8'h0c;
  localparam logic [7:0] SPG_OFF_DIRECTION = 8'h0d;
  localparam logic [7:0] SPG_OFF_LEVEL = 8'h0e;
  localparam logic [7:0] SPG_RST_ENABLE = 8'h00;
  localparam logic [7:0] SPG_RST_DIRECTION = 8'h00;
  localparam logic [7:0] SPG_RST_LEVEL = 8'h00;
  localparam logic SPG_DIR_OUTPUT = 1'b0;
  localparam logic SPG_DIR_INPUT = 1'b1;
  localparam int SPG_SYNC_STAGES = 2;
  localparam int SPG_PIN_MAX = 8;
  localparam int SPG_PIN_REFP = 0;
  localparam int SPG_PIN_REFN = 1;

  typedef struct packed {
    logic [SPG_ADDR_W-1:0] addr;
    logic [SPG_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } spg_req_type;

  typedef struct packed {
    logic [SPG_PIN_MAX-1:0] out;
    logic [SPG_PIN_MAX-1:0] oe;
  } spg_pad_type;
endpackage

// *** design/spg_sync.sv ***
// Purpose: two-stage synchroniser for pad inputs
// Assumes: pad levels are asynchronous to core_clk
// Notes: first stage feeds only the second
`timescale 1ns/100ps
module spg_sync
  import spg_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// *** verification/spg_port_assertions.sv ***
// Purpose: port checks of the shared-pin port
// Assumes: clk_en held high
// Notes: pads and claim lag a write by two edges
`timescale 1ns/100ps
module spg_port_assertions import spg_pkg::*; (input wire logic core_clk, rst, clk_en,
  input wire spg_req_type bus_req, input wire logic [7:0] rdata, pad_in, port_claim,
  input wire spg_pad_type pad_drv);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire wr = bus_req.wr & clk_en;
  wire rd = bus_req.rd & clk_en;
  wire [7:0] a = bus_req.addr;
  property p_rst; $fell(rst) |-> rdata == 0 && pad_drv == 0 && port_claim == 0; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_map; rd && (a < 8'h0c || a > 8'h0e) |=> rdata == 0; endproperty
  a_map: assert property (p_map) else $error("map");
  property p_oe; (pad_drv.oe & ~port_claim) == 0; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_out; (pad_drv.out & ~pad_drv.oe) == 0; endproperty
  a_out: assert property (p_out) else $error("out");
  property p_back; rd && a == 8'h0e |=> ((rdata ^ pad_drv.out) & pad_drv.oe) == 0; endproperty
  a_back: assert property (p_back) else $error("back");
  property p_clm; $changed(port_claim) |-> $past(wr, 2) && $past(a, 2) == 8'h0c; endproperty
  a_clm: assert property (p_clm) else $error("claim");
  property p_oec; $changed(pad_drv.oe) |-> $past(wr, 2) && $past(a, 2) inside {8'h0c, 8'h0d};
  endproperty
  a_oec: assert property (p_oec) else $error("dir");
  property p_outc; $changed(pad_drv.out) |-> $past(wr, 2); endproperty
  a_outc: assert property (p_outc) else $error("lvl");
endmodule
bind spg_port spg_port_assertions chk (.*);

// *** verification/spg_pad_model.sv ***
// Purpose: outside circuitry on the pins
// Assumes: a driven pin wins
// Notes: free pins show the bench pattern
`timescale 1ns/100ps
module spg_pad_model import spg_pkg::*; (input wire spg_pad_type drv,
  input wire logic [7:0] ext, output logic [7:0] pad);
  assign pad = (drv.oe & drv.out) | (~drv.oe & ext);
endmodule

// *** verification/spg_port_test.sv ***
// Purpose: self-checking bench of the port
// Assumes: clk_en high except during the freeze test
// Notes: lfsr seeded 93
`timescale 1ns/100ps
module spg_port_test;
  import spg_pkg::*;
  logic core_clk = 0, rst = 1;
  spg_req_type req = '0;
  logic [7:0] rdata, pad, clm, ext = 0, r = 8'd93, en, dir, lvl, rdata4, pad4, clm4;
  logic ce = 1;
  spg_pad_type drv, drv4;
  int num_errors = 0, compares = 0, cyc = 0;
  always #2 core_clk = ~core_clk;
  spg_port dut (.core_clk(core_clk), .rst(rst), .clk_en(ce), .bus_req(req),
    .rdata(rdata), .pad_in(pad), .pad_drv(drv), .port_claim(clm));
  spg_pad_model pads (.drv(drv), .ext(ext), .pad(pad));
  // four-pin variant shares the bus so its upper bits can be compared
  spg_port #(.PINS(4)) dut4 (.core_clk(core_clk), .rst(rst), .clk_en(ce), .bus_req(req),
    .rdata(rdata4), .pad_in(pad4), .pad_drv(drv4), .port_claim(clm4));
  spg_pad_model pads4 (.drv(drv4), .ext(ext), .pad(pad4));
  function automatic logic [7:0] lf(logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) req.wr <= 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge core_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk) req.rd <= 0;
    #1 chk("rdata", rdata, e);
    chk("rdata4", rdata4, e & 8'h0f);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge core_clk) if (++cyc == 4000) begin
    num_errors++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 0;
    rd(8'h0c, 0);
    rd(8'h0d, 0);
    rd(8'h0e, 0);
    wr(8'h0f, 8'hff);
    rd(8'h0f, 0);
    $display("reset test done");
    repeat (24) begin
      en = lf(r);
      dir = lf(en);
      lvl = lf(dir);
      r = lf(lvl);
      @(posedge core_clk) ext <= r;
      wr(8'h0c, en);
      wr(8'h0d, dir);
      wr(8'h0e, lvl);
      repeat (2) @(posedge core_clk);
      #1 chk("oe", drv.oe, en & ~dir);
      chk("out", drv.out, en & ~dir & lvl);
      chk("claim", clm, en);
      chk("oe4", drv4.oe, en & ~dir & 8'h0f);
      rd(8'h0d, dir);
      rd(8'h0e, lvl & ~dir | ext & dir);
    end
    $display("pin test done");
    // clock enable low: the write must be dropped
    @(posedge core_clk) ce <= 0;
    wr(8'h0d, ~dir);
    @(posedge core_clk) ce <= 1;
    rd(8'h0d, dir);
    $display("freeze test done");
    summarize();
  end
endmodule
